/* File: include/scs_defines.vh */
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// Clock and link rate
`define SCS_CLK_HZ 100000000
`define SCS_BAUD 9600

// Sequence times in milliseconds
`define SCS_T_PWRUP_MS 1500
`define SCS_T_LISTEN_MS 100
`define SCS_T_CMD_MS 1000
`define SCS_T_SLEEP_MS 20000
`define SCS_T_SEC_MS 1000

// Character codes
`define SCS_CH_LF 8'h0A
`define SCS_CH_CR 8'h0D
`define SCS_CH_TAB 8'h09
`define SCS_CH_XON 8'h11
`define SCS_CH_XOFF 8'h13
`define SCS_CH_ACK 8'h23
`define SCS_CH_NAK 8'h2A
`define SCS_CH_US 8'h5F
`define SCS_CH_SP 8'h20
`define SCS_CH_LPAR 8'h28
`define SCS_CH_RPAR 8'h29
`define SCS_CH_COMMA 8'h2C
`define SCS_CH_MINUS 8'h2D
`define SCS_CH_ZERO 8'h30
`define SCS_CH_NINE 8'h39
`define SCS_CH_LA 8'h61
`define SCS_CH_LZ 8'h7A
`define SCS_CASE_BIT 8'h20
`define SCS_HEX_ALPHA 8'h37

// Command keys: first four letters, upper case, right aligned
`define SCS_K_DO 32'h0000444F
`define SCS_K_GET 32'h00474554
`define SCS_K_SET 32'h00534554
`define SCS_K_SAVE 32'h53415645
`define SCS_K_LOAD 32'h4C4F4144
`define SCS_K_HELP 32'h48454C50
`define SCS_K_SAMP 32'h53414D50
`define SCS_K_ALL 32'h00414C4C
`define SCS_K_PROT 32'h50524F54
`define SCS_K_INTE 32'h494E5445
`define SCS_K_OUTP 32'h4F555450
`define SCS_K_MEAS 32'h4D454153

// Setting reset values; output FF selects the logger path
`define SCS_INT_DEF 16'h001E
`define SCS_OUT_DEF 8'hFF
`define SCS_OUT_LOGGER 8'hFF

// Error text letters
`define SCS_E_CMD 8'h43
`define SCS_E_VAL 8'h56
`define SCS_E_PROT 8'h50

// Reply lengths in bytes
`define SCS_LEN_OK 5'd3
`define SCS_LEN_ERR 5'd4
`define SCS_LEN_LINE 5'd11
`define SCS_LEN_ONE 5'd1
`define SCS_LEN_HELP 5'd27
`define SCS_HELP_LEN 25
`define SCS_HELP_TXT "DO GET SET SAVE LOAD HELP"

`endif

/* File: logic/scs_sequencer.v */
`include "scs_defines.vh"
`default_nettype none

// Contract
// - First measurement finished and reported within 1.5 s of power-up.
// - After each measurement, watch the receiver for 100 ms.
// - A character in that window opens a 1 s command session.
// - Quiet window means resume interval sampling.
// - Interval zero disables periodic sampling; only the sample command measures.
// - About 20 s without a valid command puts the device to sleep.
// - Asleep, received characters are ignored and nothing answers.
// - Send XOFF just before sleeping.
// - After waking and measuring, send XON.
// - Link is 9600 baud, 8 data bits, 1 stop, no parity.
// - Primary word, then secondary name after underscore or space.
// - Setting writes carry a bracketed comma separated value list; the code takes one value and answers a comma with '*V'.
// - Line feed ends a command; carriage return before it allowed.
// - Names match regardless of letter case.
// - Accept answers '#', reject '*', each followed by CR LF.
// - Rejections carry a short error letter after '*'.
// - Supports do, get, get all, set, save, load, help.
// - Measurement presented on the logger output.
// - Logger output is the default result path.
// - Read replies use tab separators and end in CR LF.
// - Protected settings need the unlock setting at 1 first.
module scs_sequencer #(
	parameter integer CLK_HZ = `SCS_CLK_HZ,
	parameter integer BAUD_DIV = CLK_HZ / `SCS_BAUD,
	parameter integer PWRUP_CYC = CLK_HZ / 1000 * `SCS_T_PWRUP_MS,
	parameter integer LISTEN_CYC = CLK_HZ / 1000 * `SCS_T_LISTEN_MS,
	parameter integer CMD_CYC = CLK_HZ / 1000 * `SCS_T_CMD_MS,
	parameter integer SLEEP_CYC = CLK_HZ / 1000 * `SCS_T_SLEEP_MS,
	parameter integer SEC_CYC = CLK_HZ / 1000 * `SCS_T_SEC_MS
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Serial line
	input wire rx_pin,
	output wire tx_pin,
	// Measurement engine
	output reg meas_start,
	input wire meas_done,
	input wire [15:0] meas_result,
	// Logger result port
	output reg [15:0] logger_serial_output,
	output reg logger_valid
);
	localparam [3:0] S_MEAS = 4'h0;
	localparam [3:0] S_DONE = 4'h1;
	localparam [3:0] S_WAKE = 4'h2;
	localparam [3:0] S_LISTEN = 4'h3;
	localparam [3:0] S_CMD = 4'h4;
	localparam [3:0] S_IDLE = 4'h5;
	localparam [3:0] S_SLEEP = 4'h6;
	localparam [3:0] S_TX = 4'h7;

	localparam [1:0] P_MAIN = 2'h0;
	localparam [1:0] P_SUB = 2'h1;
	localparam [1:0] P_VAL = 2'h2;
	localparam [1:0] P_END = 2'h3;

	localparam [2:0] K_OK = 3'h0;
	localparam [2:0] K_ERR = 3'h1;
	localparam [2:0] K_LINE = 3'h2;
	localparam [2:0] K_ONE = 3'h3;
	localparam [2:0] K_HELP = 3'h4;

	localparam [2:0] A_NONE = 3'h0;
	localparam [2:0] A_INT = 3'h1;
	localparam [2:0] A_OUT = 3'h2;
	localparam [2:0] A_PROT = 3'h3;
	localparam [2:0] A_SAVE = 3'h4;
	localparam [2:0] A_LOAD = 3'h5;
	localparam [2:0] A_SAMP = 3'h6;

	localparam [1:0] SEL_MEAS = 2'h3;
	localparam [8*`SCS_HELP_LEN-1:0] HELP_TXT = `SCS_HELP_TXT;

	// Uppercase one character
	function [7:0] upcase;
		input [7:0] c;
		begin
			if (c >= `SCS_CH_LA && c <= `SCS_CH_LZ)
				upcase = c - `SCS_CASE_BIT;
			else
				upcase = c;
		end
	endfunction

	// One hex digit as text
	function [7:0] hexc;
		input [3:0] n;
		begin
			if (n < 4'hA)
				hexc = `SCS_CH_ZERO + {4'h0, n};
			else
				hexc = `SCS_HEX_ALPHA + {4'h0, n};
		end
	endfunction

	// Reply length per kind
	function [4:0] klen;
		input [2:0] k;
		begin
			case (k)
				K_OK: klen = `SCS_LEN_OK;
				K_ERR: klen = `SCS_LEN_ERR;
				K_LINE: klen = `SCS_LEN_LINE;
				K_HELP: klen = `SCS_LEN_HELP;
				default: klen = `SCS_LEN_ONE;
			endcase
		end
	endfunction

	wire tx_rdy, rx_valid;
	wire [7:0] rx_byte;
	wire [7:0] rx_up = upcase(rx_byte);

	reg [3:0] st_r, ret_r;
	reg [31:0] tmr_r, quiet_r, pre_r;
	reg [15:0] icnt_r, int_r, int_save_r, res_r, val_r;
	reg [7:0] out_r, out_save_r, one_r, code_r, tx_data_r;
	reg prot_r, xoff_r, busy_r, due_r, valid_r, tx_go_r;
	reg [2:0] kind_r;
	reg [4:0] idx_r;
	reg [1:0] sel_r, all_r;

	// Command parser state
	reg [1:0] ph_r;
	reg [31:0] main_r, sub_r;
	reg [2:0] mcnt_r, scnt_r;
	reg neg_r, dig_r, extra_r, bad_r, cr_r;

	// Characters reach the parser only while awake and listening
	wire rx_take = rx_valid && (st_r == S_LISTEN || st_r == S_CMD);
	wire exec = rx_take && rx_byte == `SCS_CH_LF;
	wire [15:0] val_s = neg_r ? (~val_r + 16'h0001) : val_r;

	scs_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
		.sys_clk(sys_clk),
		.reset(reset),
		.rx_pin(rx_pin),
		.tx_pin(tx_pin),
		.tx_start(tx_go_r),
		.tx_byte(tx_data_r),
		.tx_rdy(tx_rdy),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte)
	);

	// Parse words, separator, value list and line end
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ph_r <= P_MAIN;
			main_r <= 32'h00000000;
			sub_r <= 32'h00000000;
			mcnt_r <= 3'h0;
			scnt_r <= 3'h0;
			val_r <= 16'h0000;
			neg_r <= 1'b0;
			dig_r <= 1'b0;
			extra_r <= 1'b0;
			bad_r <= 1'b0;
			cr_r <= 1'b0;
		end else if (rx_take) begin
			if (exec) begin
				ph_r <= P_MAIN;
				main_r <= 32'h00000000;
				sub_r <= 32'h00000000;
				mcnt_r <= 3'h0;
				scnt_r <= 3'h0;
				val_r <= 16'h0000;
				neg_r <= 1'b0;
				dig_r <= 1'b0;
				extra_r <= 1'b0;
				bad_r <= 1'b0;
				cr_r <= 1'b0;
			end else if (cr_r) begin
				bad_r <= 1'b1;
			end else if (rx_byte == `SCS_CH_CR) begin
				cr_r <= 1'b1;
			end else begin
				case (ph_r)
					P_MAIN: begin
						if (rx_up == `SCS_CH_US || rx_up == `SCS_CH_SP) begin
							if (mcnt_r != 3'h0)
								ph_r <= P_SUB;
						end else if (mcnt_r == 3'h4) begin
							bad_r <= 1'b1;
						end else begin
							main_r <= {main_r[23:0], rx_up};
							mcnt_r <= mcnt_r + 3'h1;
						end
					end
					P_SUB: begin
						if (rx_up == `SCS_CH_LPAR)
							ph_r <= P_VAL;
						else if (rx_up != `SCS_CH_SP && scnt_r != 3'h4) begin
							sub_r <= {sub_r[23:0], rx_up};
							scnt_r <= scnt_r + 3'h1;
						end
					end
					P_VAL: begin
						if (rx_up >= `SCS_CH_ZERO && rx_up <= `SCS_CH_NINE) begin
							val_r <= val_r * 16'h000A + {12'h000, rx_up[3:0]};
							dig_r <= 1'b1;
						end else if (rx_up == `SCS_CH_MINUS && !dig_r)
							neg_r <= 1'b1;
						else if (rx_up == `SCS_CH_COMMA)
							extra_r <= 1'b1;
						else if (rx_up == `SCS_CH_RPAR)
							ph_r <= P_END;
						else if (rx_up != `SCS_CH_SP)
							bad_r <= 1'b1;
					end
					default: begin
						if (rx_up != `SCS_CH_SP)
							bad_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// Decode a finished command into reply kind and action
	reg [2:0] dec_kind, dec_act;
	reg [7:0] dec_code;
	reg [1:0] dec_sel, dec_all;
	always @* begin
		dec_kind = K_ERR;
		dec_code = `SCS_E_CMD;
		dec_act = A_NONE;
		dec_sel = 2'h0;
		dec_all = 2'h0;
		if (bad_r) begin
			dec_code = `SCS_E_VAL;
		end else begin
			case (main_r)
				`SCS_K_GET: begin
					if (ph_r == P_SUB) begin
						dec_kind = K_LINE;
						case (sub_r)
							`SCS_K_PROT: dec_sel = 2'h0;
							`SCS_K_INTE: dec_sel = 2'h1;
							`SCS_K_OUTP: dec_sel = 2'h2;
							`SCS_K_ALL: dec_all = 2'h2;
							default: dec_kind = K_ERR;
						endcase
					end
				end
				`SCS_K_SET: begin
					if (ph_r != P_END || !dig_r || extra_r)
						dec_code = `SCS_E_VAL;
					else begin
						dec_kind = K_OK;
						case (sub_r)
							`SCS_K_PROT: dec_act = A_PROT;
							`SCS_K_INTE: dec_act = A_INT;
							`SCS_K_OUTP: begin
								if (prot_r)
									dec_act = A_OUT;
								else begin
									dec_kind = K_ERR;
									dec_code = `SCS_E_PROT;
								end
							end
							default: dec_kind = K_ERR;
						endcase
					end
				end
				`SCS_K_DO: begin
					if (ph_r == P_SUB && sub_r == `SCS_K_SAMP) begin
						dec_kind = K_OK;
						dec_act = A_SAMP;
					end
				end
				`SCS_K_SAVE: begin
					dec_kind = K_OK;
					dec_act = A_SAVE;
				end
				`SCS_K_LOAD: begin
					dec_kind = K_OK;
					dec_act = A_LOAD;
				end
				`SCS_K_HELP: dec_kind = K_HELP;
				default: dec_kind = K_ERR;
			endcase
		end
	end

	// Byte at the current reply position
	reg [31:0] line_name;
	reg [15:0] line_val;
	reg [7:0] rep_byte;
	always @* begin
		case (sel_r)
			2'h0: line_name = `SCS_K_PROT;
			2'h1: line_name = `SCS_K_INTE;
			2'h2: line_name = `SCS_K_OUTP;
			default: line_name = `SCS_K_MEAS;
		endcase
		case (sel_r)
			2'h0: line_val = {15'h0000, prot_r};
			2'h1: line_val = int_r;
			2'h2: line_val = {8'h00, out_r};
			default: line_val = res_r;
		endcase
		if (kind_r != K_ONE && idx_r == klen(kind_r) - 5'd2)
			rep_byte = `SCS_CH_CR;
		else if (kind_r != K_ONE && idx_r == klen(kind_r) - 5'd1)
			rep_byte = `SCS_CH_LF;
		else begin
			case (kind_r)
				K_OK: rep_byte = `SCS_CH_ACK;
				K_ERR: rep_byte = (idx_r == 5'd0) ? `SCS_CH_NAK : code_r;
				K_ONE: rep_byte = one_r;
				K_HELP: rep_byte = HELP_TXT[8 * (`SCS_HELP_LEN - 1 - idx_r) +: 8];
				default: begin
					if (idx_r < 5'd4)
						rep_byte = line_name[8 * (3 - idx_r) +: 8];
					else if (idx_r == 5'd4)
						rep_byte = `SCS_CH_TAB;
					else
						rep_byte = hexc(line_val[4 * (8 - idx_r) +: 4]);
				end
			endcase
		end
	end

	// Interval timing in whole seconds; a start pulse clears and beats the set
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pre_r <= 32'h00000000;
			icnt_r <= 16'h0000;
			due_r <= 1'b0;
		end else begin
			if (meas_start) begin
				pre_r <= 32'h00000000;
				icnt_r <= 16'h0000;
			end else if (pre_r == SEC_CYC - 1) begin
				pre_r <= 32'h00000000;
				icnt_r <= icnt_r + 16'h0001;
			end else
				pre_r <= pre_r + 32'h00000001;
			if (int_r != 16'h0000 && !meas_start && pre_r == SEC_CYC - 1 && icnt_r + 16'h0001 >= int_r)
				due_r <= 1'b1;
			else if (meas_start)
				due_r <= 1'b0;
		end
	end

	// Time since the last accepted command
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			quiet_r <= 32'h00000000;
		else if (valid_r || st_r == S_SLEEP)
			quiet_r <= 32'h00000000;
		else if (quiet_r != SLEEP_CYC)
			quiet_r <= quiet_r + 32'h00000001;
	end

	// Main sequence: measure, report, listen, serve, idle, sleep
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= S_MEAS;
			ret_r <= S_LISTEN;
			tmr_r <= 32'h00000000;
			res_r <= 16'h0000;
			int_r <= `SCS_INT_DEF;
			int_save_r <= `SCS_INT_DEF;
			out_r <= `SCS_OUT_DEF;
			out_save_r <= `SCS_OUT_DEF;
			prot_r <= 1'b0;
			one_r <= 8'h00;
			code_r <= 8'h00;
			tx_data_r <= 8'h00;
			xoff_r <= 1'b0;
			busy_r <= 1'b0;
			valid_r <= 1'b0;
			tx_go_r <= 1'b0;
			kind_r <= K_OK;
			idx_r <= 5'd0;
			sel_r <= 2'h0;
			all_r <= 2'h0;
			meas_start <= 1'b0;
			logger_serial_output <= 16'h0000;
			logger_valid <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			logger_valid <= 1'b0;
			valid_r <= 1'b0;
			tx_go_r <= 1'b0;
			case (st_r)
				S_MEAS: begin
					if (!busy_r) begin
						meas_start <= 1'b1;
						busy_r <= 1'b1;
						tmr_r <= PWRUP_CYC - 1;
					end else if (meas_done || tmr_r == 32'h00000000) begin
						busy_r <= 1'b0;
						if (meas_done)
							res_r <= meas_result;
						st_r <= S_DONE;
					end else
						tmr_r <= tmr_r - 32'h00000001;
				end
				S_DONE: begin
					if (out_r == `SCS_OUT_LOGGER) begin
						logger_serial_output <= res_r;
						logger_valid <= 1'b1;
						st_r <= S_WAKE;
					end else begin
						kind_r <= K_LINE;
						sel_r <= SEL_MEAS;
						idx_r <= 5'd0;
						ret_r <= S_WAKE;
						st_r <= S_TX;
					end
				end
				S_WAKE: begin
					tmr_r <= LISTEN_CYC - 1;
					if (xoff_r) begin
						xoff_r <= 1'b0;
						one_r <= `SCS_CH_XON;
						kind_r <= K_ONE;
						idx_r <= 5'd0;
						ret_r <= S_LISTEN;
						st_r <= S_TX;
					end else
						st_r <= S_LISTEN;
				end
				S_LISTEN, S_CMD: begin
					if (exec) begin
						tmr_r <= CMD_CYC - 1;
						valid_r <= dec_kind != K_ERR;
						kind_r <= dec_kind;
						code_r <= dec_code;
						sel_r <= dec_sel;
						all_r <= dec_all;
						idx_r <= 5'd0;
						ret_r <= (dec_act == A_SAMP) ? S_MEAS : S_CMD;
						st_r <= S_TX;
						case (dec_act)
							A_INT: int_r <= val_s;
							A_OUT: out_r <= val_s[7:0];
							A_PROT: prot_r <= val_s == 16'h0001;
							A_SAVE: begin
								int_save_r <= int_r;
								out_save_r <= out_r;
								prot_r <= 1'b0;
							end
							A_LOAD: begin
								int_r <= int_save_r;
								out_r <= out_save_r;
								prot_r <= 1'b0;
							end
							default: prot_r <= prot_r;
						endcase
					end else if (rx_take) begin
						tmr_r <= CMD_CYC - 1;
						st_r <= S_CMD;
					end else if (tmr_r == 32'h00000000)
						st_r <= S_IDLE;
					else
						tmr_r <= tmr_r - 32'h00000001;
				end
				S_IDLE: begin
					if (due_r)
						st_r <= S_MEAS;
					else if (quiet_r == SLEEP_CYC) begin
						xoff_r <= 1'b1;
						one_r <= `SCS_CH_XOFF;
						kind_r <= K_ONE;
						idx_r <= 5'd0;
						ret_r <= S_SLEEP;
						st_r <= S_TX;
					end
				end
				S_SLEEP: begin
					if (due_r)
						st_r <= S_MEAS;
				end
				S_TX: begin
					if (tx_rdy && !tx_go_r) begin
						if (idx_r != klen(kind_r)) begin
							tx_data_r <= rep_byte;
							tx_go_r <= 1'b1;
							idx_r <= idx_r + 5'd1;
						end else if (all_r != 2'h0) begin
							all_r <= all_r - 2'h1;
							sel_r <= sel_r + 2'h1;
							idx_r <= 5'd0;
						end else
							st_r <= ret_r;
					end
				end
				default: st_r <= S_MEAS;
			endcase
		end
	end
endmodule // scs_sequencer

`default_nettype wire

/* File: logic/scs_uart.v */
`include "scs_defines.vh"
`default_nettype none

module scs_uart #(
	parameter integer BAUD_DIV = `SCS_CLK_HZ / `SCS_BAUD
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Line pins
	input wire rx_pin,
	output reg tx_pin,
	// Transmit side
	input wire tx_start,
	input wire [7:0] tx_byte,
	output wire tx_rdy,
	// Receive side
	output reg rx_valid,
	output reg [7:0] rx_byte
);
	// Counter reloads cut to the counter width on purpose
	localparam integer DIV_M1_I = BAUD_DIV - 1;
	localparam integer DIV_HALF_I = BAUD_DIV / 2;
	localparam [13:0] DIV_M1 = DIV_M1_I[13:0];
	localparam [13:0] DIV_HALF = DIV_HALF_I[13:0];
	localparam [3:0] LAST_BIT = 4'h9;

	reg rx_s1_r, rx_s2_r, rx_busy_r, tx_busy_r;
	reg [13:0] rx_cnt_r, tx_cnt_r;
	reg [3:0] rx_bit_r, tx_bit_r;
	reg [7:0] rx_sh_r;
	reg [9:0] tx_sh_r;

	assign tx_rdy = !tx_busy_r;

	// Receiver: start, eight data bits, one stop bit, sampled mid bit
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 14'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
			rx_valid <= 1'b0;
			if (!rx_busy_r) begin
				if (!rx_s2_r) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= DIV_HALF;
					rx_bit_r <= 4'h0;
				end
			end else if (rx_cnt_r != 14'h0000) begin
				rx_cnt_r <= rx_cnt_r - 14'h0001;
			end else begin
				rx_cnt_r <= DIV_M1;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0 && rx_s2_r)
					rx_busy_r <= 1'b0; // Glitch, not a start bit
				else if (rx_bit_r == LAST_BIT) begin
					rx_busy_r <= 1'b0;
					rx_valid <= rx_s2_r;
					rx_byte <= rx_sh_r;
				end else if (rx_bit_r != 4'h0)
					rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
			end
		end
	end

	// Transmitter: ten bit frame, no parity
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= 14'h0000;
			tx_bit_r <= 4'h0;
			tx_sh_r <= 10'h3FF;
			tx_pin <= 1'b1;
		end else if (!tx_busy_r) begin
			tx_pin <= 1'b1;
			if (tx_start) begin
				tx_busy_r <= 1'b1;
				tx_sh_r <= {1'b1, tx_byte, 1'b0};
				tx_cnt_r <= 14'h0000;
				tx_bit_r <= 4'h0;
			end
		end else if (tx_cnt_r != 14'h0000) begin
			tx_cnt_r <= tx_cnt_r - 14'h0001;
		end else if (tx_bit_r == LAST_BIT + 4'h1) begin
			tx_busy_r <= 1'b0;
		end else begin
			tx_pin <= tx_sh_r[0];
			tx_sh_r <= {1'b1, tx_sh_r[9:1]};
			tx_bit_r <= tx_bit_r + 4'h1;
			tx_cnt_r <= DIV_M1;
		end
	end
endmodule // scs_uart

`default_nettype wire

/* File: testbench/scs_host_model.sv */
`default_nettype none
module scs_host_model #(
	parameter integer BAUD_DIV = 16
) (
	// Clock
	input wire logic sys_clk,
	// Serial lines
	input wire logic dev_tx,
	output logic host_tx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	logic paused = 1'b0;
	logic frame_err = 1'b0;
	initial host_tx = 1'b1;

	// Collect device characters, LSB first, stop bit checked; flow control obeyed
	initial begin : rx_proc
		logic [7:0] b;
		forever begin
			@(negedge sys_clk iff dev_tx === 1'b0);
			repeat (BAUD_DIV / 2) @(negedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BAUD_DIV) @(negedge sys_clk);
				b[i] = dev_tx;
			end
			repeat (BAUD_DIV) @(negedge sys_clk);
			if (dev_tx !== 1'b1) frame_err = 1'b1;
			rx_q.push_back(b);
			if (b == 8'h13) paused = 1'b1;
			if (b == 8'h11) paused = 1'b0;
		end
	end

	// Send text as 8N1 frames; raw sends even while paused
	task automatic send(input string s, input bit raw);
		logic [9:0] f;
		for (int k = 0; k < s.len(); k++) begin
			if (!raw) wait (paused == 1'b0);
			f = {1'b1, s[k], 1'b0};
			for (int j = 0; j < 10; j++) begin
				@(negedge sys_clk) host_tx = f[j];
				repeat (BAUD_DIV - 1) @(negedge sys_clk);
			end
		end
	endtask
endmodule // scs_host_model
`default_nettype wire

/* File: testbench/scs_seq_asserts.sv */
`default_nettype none
module scs_seq_asserts #(
	parameter integer BAUD_DIV = 16,
	parameter integer LISTEN_CYC = 400
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Serial line
	input wire logic rx_pin,
	input wire logic tx_pin,
	// Measurement engine
	input wire logic meas_start,
	input wire logic meas_done,
	input wire logic [15:0] meas_result,
	// Logger result port
	input wire logic [15:0] logger_serial_output,
	input wire logic logger_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tx_q_r;
	int frm_r;
	int lst_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// Frame position on the transmit line and listen window length
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_q_r <= 1'b1;
			frm_r <= 0;
			lst_r <= 0;
		end else begin
			tx_q_r <= tx_pin;
			if (frm_r != 0)
				frm_r <= (frm_r == 10 * BAUD_DIV - 1) ? 0 : frm_r + 1;
			else if (tx_q_r && !tx_pin)
				frm_r <= 1;
			lst_r <= logger_valid ? LISTEN_CYC : ((lst_r != 0) ? lst_r - 1 : 0);
		end
	end

	a_first_meas: assert property ($fell(reset) |-> ##[0:2] meas_start)
		else $error("no measurement after reset");
	a_done_report: assert property (meas_done |-> ##2 logger_valid)
		else $error("result not reported");
	a_report_cause: assert property (logger_valid |-> $past(meas_done, 2))
		else $error("report without result");
	a_report_data: assert property (logger_valid |-> logger_serial_output == $past(meas_result, 2))
		else $error("report data wrong");
	a_report_hold: assert property (!logger_valid |-> $stable(logger_serial_output))
		else $error("report data moved");
	a_report_pulse: assert property (logger_valid |=> !logger_valid)
		else $error("report pulse too long");
	a_tx_idle_reset: assert property (disable iff (1'b0) reset |-> tx_pin)
		else $error("line not idle in reset");
	a_start_bit: assert property (frm_r == 8 |-> !tx_pin)
		else $error("start bit short");
	a_stop_bit: assert property (frm_r == 10 * BAUD_DIV - 8 |-> tx_pin)
		else $error("stop bit missing");
	a_listen_gap: assert property (lst_r != 0 |-> !meas_start)
		else $error("sample inside listen window");
endmodule // scs_seq_asserts

bind scs_sequencer scs_seq_asserts #(.BAUD_DIV(BAUD_DIV), .LISTEN_CYC(LISTEN_CYC)) scs_seq_asserts_i (
	.sys_clk(sys_clk), .reset(reset), .rx_pin(rx_pin), .tx_pin(tx_pin), .meas_start(meas_start),
	.meas_done(meas_done), .meas_result(meas_result), .logger_serial_output(logger_serial_output),
	.logger_valid(logger_valid));
`default_nettype wire

/* File: testbench/scs_sequencer_tb_top.sv */
`default_nettype none
module scs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b0;
	logic rx_pin;
	logic tx_pin;
	logic meas_start;
	logic meas_done = 1'b0;
	logic [15:0] meas_result = 16'h0000;
	logic [15:0] logger_serial_output;
	logic logger_valid;
	int n_mismatch = 0;
	int n_checks = 0;
	int n_meas = 0;
	int gap = 0;
	time t_meas = 0;

	// Shortened timing for simulation
	localparam int BAUD = 16;
	localparam int PWRUP = 2000;
	localparam int LISTEN = 400;
	localparam int SESSION = 2000;
	localparam int SLEEP = 20000;
	localparam int SEC = 100;

	scs_sequencer #(.BAUD_DIV(BAUD), .PWRUP_CYC(PWRUP), .LISTEN_CYC(LISTEN), .CMD_CYC(SESSION), .SLEEP_CYC(SLEEP),
		.SEC_CYC(SEC)) scs_sequencer_i (.sys_clk(sys_clk), .reset(reset), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.meas_start(meas_start), .meas_done(meas_done), .meas_result(meas_result),
		.logger_serial_output(logger_serial_output), .logger_valid(logger_valid));
	scs_host_model #(.BAUD_DIV(BAUD)) scs_host_model_i (.sys_clk(sys_clk), .dev_tx(tx_pin), .host_tx(rx_pin));

	// Clock
	initial forever #5 sys_clk = ~sys_clk;

	// Measurement engine answers 20 cycles after each request
	initial forever begin
		@(negedge sys_clk iff meas_start === 1'b1);
		n_meas++;
		gap = int'(($time - t_meas) / 10);
		t_meas = $time;
		repeat (20) @(negedge sys_clk);
		meas_result = 16'hA500 + n_meas[15:0];
		meas_done = 1'b1;
		@(negedge sys_clk) meas_done = 1'b0;
	end

	task automatic chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask

	task automatic wait_rx(input int n, input int lim);
		for (int t = 0; t < lim && scs_host_model_i.rx_q.size() < n; t++) @(negedge sys_clk);
	endtask

	task automatic wait_meas(input int n, input int lim);
		for (int t = 0; t < lim && n_meas < n; t++) @(negedge sys_clk);
	endtask

	// Send one command line and compare the whole reply
	task automatic cmd(input string c, input string e);
		scs_host_model_i.rx_q.delete();
		scs_host_model_i.send(c, 1'b0);
		wait_rx(e.len(), 6000);
		repeat (320) @(negedge sys_clk);
		chk(scs_host_model_i.rx_q.size() == e.len(), "reply length");
		for (int i = 0; i < e.len() && i < scs_host_model_i.rx_q.size(); i++)
			chk(scs_host_model_i.rx_q[i] === e[i], "reply byte");
	endtask

	task automatic t_power;
		int t;
		for (t = 0; t < 2100 && logger_valid !== 1'b1; t++) @(negedge sys_clk);
		chk(t <= 2000, "first report late");
		chk(logger_serial_output === 16'hA501, "first result");
		$display("test power-up report done");
	endtask

	task automatic t_cmds;
		cmd("get_interval\n", "INTE\t001E\r\n");
		cmd("SET INTE(20)\r\n", "#\r\n");
		cmd("FOO\n", "*C\r\n");
		cmd("Set_Output(1)\n", "*P\r\n");
		cmd("SET INTE(1,2)\n", "*V\r\n");
		cmd("GET INTE\n", "INTE\t0014\r\n");
		cmd("SET PROT(1)\n", "#\r\n");
		cmd("set outp(255)\n", "#\r\n");
		cmd("GET ALL\n", "PROT\t0001\r\nINTE\t0014\r\nOUTP\t00FF\r\n");
		cmd("Help\n", "DO GET SET SAVE LOAD HELP\r\n");
		cmd("SAVE\n", "#\r\n");
		cmd("LOAD\n", "#\r\n");
		$display("test command set done");
	endtask

	task automatic t_interval;
		wait_meas(n_meas + 3, 9000);
		// Twenty seconds of interval, one cycle for the start pulse to clear the count, two from due flag through idle to the start pulse
		chk(gap == 20 * SEC + 3, "sample period");
		$display("test interval sampling done");
	endtask

	task automatic t_sleep;
		int t;
		scs_host_model_i.rx_q.delete();
		for (t = 0; t < 25000 && scs_host_model_i.paused !== 1'b1; t++) @(negedge sys_clk);
		chk(scs_host_model_i.rx_q.size() == 1 && scs_host_model_i.rx_q[0] === 8'h13, "no pause char");
		scs_host_model_i.send("?\n", 1'b1);
		for (t = 0; t < 2500 && logger_valid !== 1'b1; t++) @(negedge sys_clk);
		chk(scs_host_model_i.rx_q.size() == 1, "answer while asleep");
		wait_rx(2, 400);
		chk(scs_host_model_i.rx_q.size() == 2 && scs_host_model_i.rx_q[1] === 8'h11, "no resume char");
		$display("test sleep and wake done");
	endtask

	task automatic t_zero;
		int n0;
		cmd("SET INTE(0)\n", "#\r\n");
		n0 = n_meas;
		repeat (1500) @(negedge sys_clk);
		chk(n_meas == n0, "periodic sample");
		cmd("do sample\n", "#\r\n");
		wait_meas(n0 + 1, 300);
		chk(n_meas == n0 + 1, "sample command");
		chk(scs_host_model_i.frame_err === 1'b0, "reply framing");
		$display("test triggered sampling done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		#1 reset = 1'b1; // Edge after time zero clears the design before the first clock
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		t_power();
		t_cmds();
		t_interval();
		t_sleep();
		t_zero();
		test_done();
	end

	// Watchdog
	initial begin
		repeat (95000) @(posedge sys_clk);
		n_mismatch++;
		$display("wrong value at %0t ns: run timed out", $time);
		test_done();
	end
endmodule // scs_sequencer_tb_top
`default_nettype wire
